//--- wdtw_axil.sv
// axi4-lite slave front end: registered answers, one access each way
`timescale 1ns/1ns
module wdtw_axil (
	input  wire logic                        i_mclk,
	input  wire logic                        i_resetn,
	input  wire logic [wdtw_pkg::ADDR_W-1:0] i_awaddr,
	input  wire logic                        i_awvalid,
	output logic                             o_awready,
	input  wire logic [31:0]                 i_wdata,
	input  wire logic [3:0]                  i_wstrb,
	input  wire logic                        i_wvalid,
	output logic                             o_wready,
	output logic [1:0]                       o_bresp,
	output logic                             o_bvalid,
	input  wire logic                        i_bready,
	input  wire logic [wdtw_pkg::ADDR_W-1:0] i_araddr,
	input  wire logic                        i_arvalid,
	output logic                             o_arready,
	output logic [31:0]                      o_rdata,
	output logic [1:0]                       o_rresp,
	output logic                             o_rvalid,
	input  wire logic                        i_rready,
	output logic                             o_wr_en,
	output logic [wdtw_pkg::ADDR_W-1:0]      o_wr_addr,
	output logic [31:0]                      o_wr_data,
	output logic [3:0]                       o_wr_strb,
	input  wire logic                        i_wr_err,
	output logic [wdtw_pkg::ADDR_W-1:0]      o_rd_addr,
	input  wire logic [31:0]                 i_rd_data,
	input  wire logic                        i_rd_err
);
	logic aw_have_q;
	logic w_have_q;

	wire aw_hs   = i_awvalid && o_awready;
	wire w_hs    = i_wvalid && o_wready;
	wire ar_hs   = i_arvalid && o_arready;
	wire do_wr   = aw_have_q && w_have_q && !o_bvalid;

	assign o_wr_en   = do_wr;
	assign o_rd_addr = i_araddr;

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			o_awready <= 1'b1;
			o_wready  <= 1'b1;
			o_wr_addr <= '0;
			o_wr_data <= '0;
			o_wr_strb <= '0;
			o_bvalid  <= 1'b0;
			o_bresp   <= wdtw_pkg::RESP_OKAY;
		end else begin
			if (aw_hs) begin
				o_wr_addr <= i_awaddr;
				aw_have_q <= 1'b1;
				o_awready <= 1'b0;
			end
			if (w_hs) begin
				o_wr_data <= i_wdata;
				o_wr_strb <= i_wstrb;
				w_have_q  <= 1'b1;
				o_wready  <= 1'b0;
			end
			if (do_wr) begin
				o_bvalid  <= 1'b1;
				o_bresp   <= i_wr_err ? wdtw_pkg::RESP_SLVERR : wdtw_pkg::RESP_OKAY;
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
			end
			if (o_bvalid && i_bready) begin
				o_bvalid  <= 1'b0;
				o_awready <= 1'b1;
				o_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_arready <= 1'b1;
			o_rvalid  <= 1'b0;
			o_rdata   <= '0;
			o_rresp   <= wdtw_pkg::RESP_OKAY;
		end else if (ar_hs) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b1;
			o_rdata   <= i_rd_data;
			o_rresp   <= i_rd_err ? wdtw_pkg::RESP_SLVERR : wdtw_pkg::RESP_OKAY;
		end else if (o_rvalid && i_rready) begin
			o_rvalid  <= 1'b0;
			o_arready <= 1'b1;
		end
	end
endmodule

//--- wdtw_osc_tick.sv
// low-power oscillator tick: one-cycle enable at the nominal rate
`timescale 1ns/1ns
module wdtw_osc_tick #(
	parameter int unsigned DIV = wdtw_pkg::OSC_DIV
) (
	input  wire logic i_mclk,
	input  wire logic i_resetn,
	input  wire logic i_run,
	output logic      o_tick
);
	localparam logic [wdtw_pkg::DIV_W-1:0] LAST = wdtw_pkg::DIV_W'(DIV - 1);

	logic [wdtw_pkg::DIV_W-1:0] cnt_q;
	wire                        wrap = (cnt_q == LAST);

	always_ff @(posedge i_mclk) begin
		if (!i_resetn || !i_run) begin
			cnt_q  <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
			o_tick <= wrap;
		end
	end
endmodule

//--- wdtw_pkg.sv
// shared constants and types for the windowed watchdog
package wdtw_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_HZ     = 25_000_000;
	localparam int unsigned OSC_KHZ    = 32;
	localparam int unsigned OSC_DIV    = CLK_HZ / (OSC_KHZ * 1000);
	localparam int unsigned PRE_SHORT  = 32;
	localparam int unsigned PRE_LONG   = 128;
	localparam int unsigned BASE_SHORT_MS = 1;
	localparam int unsigned BASE_LONG_MS  = 4;
	localparam int unsigned CNT_W      = 23;
	localparam int unsigned DIV_W      = 16;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0]  ADDR_W      = 4'h4;
	localparam logic [31:0] OFS_RSTCTL  = 32'h0000_0000;
	localparam logic [31:0] OFS_CFG     = 32'h0000_0004;
	localparam logic [31:0] OFS_COUNT   = 32'h0000_0008;
	localparam int unsigned BIT_IDLE    = 2;
	localparam int unsigned BIT_SLEEP   = 3;
	localparam int unsigned BIT_TO      = 4;
	localparam int unsigned BIT_SWEN    = 5;
	localparam int unsigned CFG_POST_LO = 0;
	localparam int unsigned CFG_POST_HI = 3;
	localparam int unsigned CFG_PRESEL  = 4;
	localparam int unsigned CFG_WINDOW_DISABLE_BIT  = 6;
	localparam int unsigned CFG_FUSEEN  = 7;
	localparam logic [7:0]  CFG_RESET   = 8'h4f;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		WDTW_RUN,
		WDTW_SLEEP,
		WDTW_IDLE
	} wdtw_mode_t;
endpackage

//--- wdtw_tb.sv
// self-checking bench for the windowed watchdog
`timescale 1ns/1ns
module tb;
	localparam int unsigned OD = 4;
	localparam logic [3:0] A_CTL = wdtw_pkg::OFS_RSTCTL[3:0];
	localparam logic [3:0] A_CFG = wdtw_pkg::OFS_CFG[3:0];
	localparam logic [3:0] A_CNT = wdtw_pkg::OFS_COUNT[3:0];
	logic        i_mclk, i_resetn, o_wdt_reset, o_wake, o_low_power_rc_osc_en;
	logic [5:0]  ev;
	logic [3:0]  i_awaddr, i_araddr, i_wstrb;
	logic [31:0] i_wdata, o_rdata, rd;
	logic [1:0]  o_bresp, o_rresp, rsp;
	logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
	logic        i_arvalid, o_arready, o_rvalid, i_rready;
	int          mismatches = 0, n_checks = 0, cyc = 0, n_rst = 0, n, m;

	wdtw_top #(.OSC_DIV(OD)) u_dut (.i_mclk, .i_resetn, .i_dev_reset(ev[4]),
		.i_clear_watchdog_instr(ev[0]), .i_power_save_sleep(ev[2]), .i_power_save_idle(ev[5]),
		.i_exit_low_power(ev[3]), .i_clk_switch_done(ev[1]), .o_wdt_reset, .o_wake,
		.o_low_power_rc_osc_en, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
		.i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
		.o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready);

	initial begin
		i_mclk = 1'b0;
		forever #20 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (o_wdt_reset === 1'b1)
			n_rst <= n_rst + 1;
		if (cyc == 30000) begin
			mismatches++;
			report_and_stop();
		end
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic pulse(input int i);
		@(posedge i_mclk);
		ev[i] <= 1'b1;
		@(posedge i_mclk);
		ev[i] <= 1'b0;
	endtask
	// cycles until the chosen output pulses, lim if it never does
	task automatic wait_out(input bit wk, input int lim, output int k);
		k = 0;
		while (k < lim) begin
			@(posedge i_mclk);
			#1;
			k++;
			if ((wk ? o_wake : o_wdt_reset) === 1'b1)
				break;
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge i_mclk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (o_awready === 1'b1)
				i_awvalid <= 1'b0;
			if (o_wready === 1'b1)
				i_wvalid <= 1'b0;
		end while (o_bvalid !== 1'b1);
		r = o_bresp;
		i_bready <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge i_mclk);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_mclk);
			if (o_arready === 1'b1)
				i_arvalid <= 1'b0;
		end while (o_rvalid !== 1'b1);
		d = o_rdata;
		r = o_rresp;
		i_rready <= 1'b0;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset();
		rdr(A_CFG, rd, rsp);
		chk("cfg reset", {24'h00_0000, wdtw_pkg::CFG_RESET}, rd);
		rdr(A_CTL, rd, rsp);
		chk("ctl reset", 32'h0000_0000, rd);
		chk("osc off", 32'h0000_0000, {31'h0, o_low_power_rc_osc_en});
		rdr(4'hc, rd, rsp);
		chk("bad read", {30'h0, wdtw_pkg::RESP_SLVERR}, {30'h0, rsp});
		wr(4'hc, 32'h0000_00ff, rsp);
		chk("bad write", {30'h0, wdtw_pkg::RESP_SLVERR}, {30'h0, rsp});
		$display("test reset done");
	endtask
	task automatic t_period(input logic [7:0] cfg, input int p);
		wr(A_CFG, {24'h00_0000, cfg}, rsp);
		wait_out(0, p * OD + 40, n);
		wait_out(0, p * OD + 40, n);
		chk("period", 32'(p * OD), 32'(n));
		rdr(A_CTL, rd, rsp);
		chk("flag set", 32'h0000_0010, rd & 32'h0000_0010);
		wr(A_CTL, 32'h0000_0000, rsp);
		rdr(A_CTL, rd, rsp);
		chk("flag cleared", 32'h0000_0000, rd & 32'h0000_0010);
		$display("test period %0d done", p);
	endtask
	task automatic t_soft();
		wr(A_CFG, 32'h0000_0040, rsp);
		wait_out(0, 300, n);
		chk("idle when off", 32'd300, 32'(n));
		wr(A_CTL, 32'h0000_0020, rsp);
		wait_out(0, 32 * OD + 40, n);
		chk("runs soft", 32'h0000_0001, {31'h0, o_wdt_reset});
		chk("osc on", 32'h0000_0001, {31'h0, o_low_power_rc_osc_en});
		wr(A_CFG, 32'h0000_00c0, rsp);
		wr(A_CTL, 32'h0000_0000, rsp);
		wait_out(0, 32 * OD + 40, n);
		chk("fuse holds", 32'h0000_0001, {31'h0, o_wdt_reset});
		wr(A_CFG, 32'h0000_0040, rsp);
		wr(A_CTL, 32'h0000_0020, rsp);
		pulse(4);
		rdr(A_CTL, rd, rsp);
		chk("soft cleared", 32'h0000_0000, rd & 32'h0000_0020);
		$display("test soft enable done");
	endtask
	// clear, switch, sleep, exit, device reset each zero the count
	task automatic t_clears();
		wr(A_CFG, 32'h0000_00d0, rsp);
		for (int i = 0; i < 5; i++) begin
			repeat (200) @(posedge i_mclk);
			rdr(A_CNT, rd, rsp);
			chk("count runs", 32'h0000_0001, {31'h0, rd > 32'd40});
			pulse(i);
			rdr(A_CNT, rd, rsp);
			chk("count zeroed", 32'h0000_0001, {31'h0, rd < 32'd3});
		end
		$display("test clears done");
	endtask
	task automatic t_lowpower(input bit idle);
		wr(A_CFG, 32'h0000_00c0, rsp);
		m = n_rst;
		pulse(idle ? 5 : 2);
		wait_out(1, 32 * OD + 40, n);
		chk("wake", 32'h0000_0001, {31'h0, o_wake});
		chk("no reset", 32'(m), 32'(n_rst));
		rdr(A_CTL, rd, rsp);
		chk("status", idle ? 32'h0000_0014 : 32'h0000_0018, rd);
		wr(A_CTL, 32'h0000_0000, rsp);
		rdr(A_CTL, rd, rsp);
		chk("status cleared", 32'h0000_0000, rd);
		pulse(3);
		$display("test low power %0d done", idle);
	endtask
	task automatic t_window();
		wr(A_CFG, 32'h0000_0080, rsp);
		pulse(1);
		repeat (40) @(posedge i_mclk);
		m = n_rst;
		pulse(0);
		repeat (4) @(posedge i_mclk);
		chk("early clear", 32'(m + 1), 32'(n_rst));
		repeat (110) @(posedge i_mclk);
		m = n_rst;
		pulse(0);
		repeat (6) @(posedge i_mclk);
		chk("late clear", 32'(m), 32'(n_rst));
		$display("test window done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		i_resetn = 1'b0;
		ev = 6'h00;
		{i_awaddr, i_araddr, i_wdata} = '0;
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
		i_wstrb = 4'hf;
		repeat (8) @(posedge i_mclk);
		i_resetn <= 1'b1;
		t_reset();
		t_period(8'hc0, 32);
		t_period(8'hd0, 128);
		t_period(8'hc1, 64);
		t_period(8'hc2, 128);
		t_soft();
		t_clears();
		t_lowpower(1'b0);
		t_lowpower(1'b1);
		t_window();
		report_and_stop();
	end
endmodule

//--- wdtw_tb_assertions.sv
// concurrent checks on the watchdog top ports
`timescale 1ns/1ns
module wdtw_chk #(
	parameter int unsigned OSC_DIV = 4
) (
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_dev_reset,
	input wire logic i_power_save_sleep,
	input wire logic i_power_save_idle,
	input wire logic i_exit_low_power,
	input wire logic o_wdt_reset,
	input wire logic o_wake,
	input wire logic o_low_power_rc_osc_en,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic i_rready
);
	// ****************************************
	// low-power mode tracked from the pulses
	// ****************************************
	logic lp_q;
	always_ff @(posedge i_mclk) begin
		if (!i_resetn || i_dev_reset || i_exit_low_power)
			lp_q <= 1'b0;
		else if (i_power_save_sleep || i_power_save_idle)
			lp_q <= 1'b1;
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_resetn);
	sequence s_wr_taken;
		i_awvalid && o_awready && i_wvalid && o_wready;
	endsequence
	sequence s_rd_taken;
		i_arvalid && o_arready;
	endsequence
	// ****************************************
	// properties
	// ****************************************
	rst_pulse_one_a: assert property (o_wdt_reset |=> !o_wdt_reset)
		else $error("reset request longer than one cycle");
	wake_pulse_one_a: assert property (o_wake |=> !o_wake)
		else $error("wake request longer than one cycle");
	wake_not_reset_a: assert property (!(o_wdt_reset && o_wake))
		else $error("wake and reset requested together");
	osc_needed_a: assert property ((o_wdt_reset || o_wake) |->
		(o_low_power_rc_osc_en || $past(o_low_power_rc_osc_en)))
		else $error("time-out seen with oscillator off");
	wake_in_lp_a: assert property (o_wake |-> (lp_q || $past(lp_q)))
		else $error("wake request outside sleep or idle");
	wr_answer_a: assert property (s_wr_taken |=> ##1 o_bvalid)
		else $error("write response late");
	rd_answer_a: assert property (s_rd_taken |=> o_rvalid)
		else $error("read data late");
	b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid)
		else $error("write response dropped");
	r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid)
		else $error("read data dropped");
endmodule
bind wdtw_top wdtw_chk #(.OSC_DIV(OSC_DIV)) u_chk (.i_mclk(i_mclk), .i_resetn(i_resetn),
	.i_dev_reset(i_dev_reset), .i_power_save_sleep(i_power_save_sleep),
	.i_power_save_idle(i_power_save_idle), .i_exit_low_power(i_exit_low_power),
	.o_wdt_reset(o_wdt_reset), .o_wake(o_wake), .o_low_power_rc_osc_en(o_low_power_rc_osc_en),
	.i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
	.o_bvalid(o_bvalid), .i_bready(i_bready), .i_arvalid(i_arvalid), .o_arready(o_arready),
	.o_rvalid(o_rvalid), .i_rready(i_rready));

//--- wdtw_top.sv
// windowed watchdog timer with prescaler, postscaler and register front end
//
// Behaviour
// - counter ticks from 32 kHz low-power oscillator
// - enabling watchdog also enables its oscillator
// - prescaler divides by 32 or 128
// - select bit one means 128, zero 32
// - base period 1 ms or 4 ms
// - 4-bit postscale field picks sixteen ratios
// - field 1111 selects ratio 1:32768
// - completed clock switch zeroes all counts
// - power-save instruction zeroes all counts
// - leaving sleep or idle zeroes counts
// - clear instruction in normal run zeroes counts
// - enabled watchdog keeps counting in sleep, idle
// - time-out in low power wakes, no reset
// - time-out flag set, held until software clears
// - fuse enable forces watchdog on always
// - otherwise runs only while soft enable set
// - every device reset clears soft enable
// - early clear in window mode resets device
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
module wdtw_top #(
	parameter int unsigned OSC_DIV = wdtw_pkg::OSC_DIV
) (
	input  wire logic                        i_mclk,
	input  wire logic                        i_resetn,
	input  wire logic                        i_dev_reset,
	input  wire logic                        i_clear_watchdog_instr,
	input  wire logic                        i_power_save_sleep,
	input  wire logic                        i_power_save_idle,
	input  wire logic                        i_exit_low_power,
	input  wire logic                        i_clk_switch_done,
	output logic                             o_wdt_reset,
	output logic                             o_wake,
	output logic                             o_low_power_rc_osc_en,
	input  wire logic [wdtw_pkg::ADDR_W-1:0] i_awaddr,
	input  wire logic                        i_awvalid,
	output logic                             o_awready,
	input  wire logic [31:0]                 i_wdata,
	input  wire logic [3:0]                  i_wstrb,
	input  wire logic                        i_wvalid,
	output logic                             o_wready,
	output logic [1:0]                       o_bresp,
	output logic                             o_bvalid,
	input  wire logic                        i_bready,
	input  wire logic [wdtw_pkg::ADDR_W-1:0] i_araddr,
	input  wire logic                        i_arvalid,
	output logic                             o_arready,
	output logic [31:0]                      o_rdata,
	output logic [1:0]                       o_rresp,
	output logic                             o_rvalid,
	input  wire logic                        i_rready
);
	// ****************************************
	// helpers
	// ****************************************
	// period in oscillator ticks: prescale times two to the field
	function automatic logic [wdtw_pkg::CNT_W-1:0] period_of(input logic [7:0] cfg);
		logic [wdtw_pkg::CNT_W-1:0] pre;
		pre = cfg[wdtw_pkg::CFG_PRESEL] ? wdtw_pkg::CNT_W'(wdtw_pkg::PRE_LONG)
		                                : wdtw_pkg::CNT_W'(wdtw_pkg::PRE_SHORT);
		return pre << cfg[wdtw_pkg::CFG_POST_HI:wdtw_pkg::CFG_POST_LO];
	endfunction

	function automatic logic addr_is(input logic [wdtw_pkg::ADDR_W-1:0] a,
	                                 input logic [31:0] ofs);
		return a == ofs[wdtw_pkg::ADDR_W-1:0];
	endfunction

	// ****************************************
	// state
	// ****************************************
	logic [7:0]                 cfg_q;
	logic                       soft_en_q;
	logic                       flag_to_q;
	logic                       stat_sleep_q;
	logic                       stat_idle_q;
	wdtw_pkg::wdtw_mode_t       mode_q;
	wdtw_pkg::wdtw_mode_t       mode_d;
	logic [wdtw_pkg::CNT_W-1:0] elapsed_q;
	logic                       tick;

	logic                        wr_en;
	logic [wdtw_pkg::ADDR_W-1:0] wr_addr;
	logic [31:0]                 wr_data;
	logic [3:0]                  wr_strb;
	logic [wdtw_pkg::ADDR_W-1:0] rd_addr;

	// ****************************************
	// oscillator and counting
	// ****************************************
	wire wdt_en = cfg_q[wdtw_pkg::CFG_FUSEEN] | soft_en_q;

	wdtw_osc_tick #(
		.DIV (OSC_DIV)
	) u_osc (
		.i_mclk   (i_mclk),
		.i_resetn (i_resetn),
		.i_run    (o_low_power_rc_osc_en),
		.o_tick   (tick)
	);

	wire                        running   = (mode_q == wdtw_pkg::WDTW_RUN);
	wire [wdtw_pkg::CNT_W-1:0]  period    = period_of(cfg_q);
	wire [wdtw_pkg::CNT_W-1:0]  win_open  = period - (period >> 2);
	wire                        timeout   = wdt_en && tick && (elapsed_q + 1'b1 == period);
	wire                        clr_instr = i_clear_watchdog_instr && running;
	wire                        early     = clr_instr && wdt_en
	                                        && !cfg_q[wdtw_pkg::CFG_WINDOW_DISABLE_BIT]
	                                        && (elapsed_q < win_open);
	wire                        rst_d     = (timeout && running) || early;
	wire                        wake_d    = timeout && !running;
	wire                        dev_rst   = i_dev_reset || o_wdt_reset;
	wire                        clr_cnt   = dev_rst || i_clk_switch_done
	                                        || i_power_save_sleep || i_power_save_idle
	                                        || i_exit_low_power
	                                        || clr_instr || !wdt_en;

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			elapsed_q <= '0;
		end else if (clr_cnt) begin
			elapsed_q <= '0;
		end else if (tick && wdt_en) begin
			elapsed_q <= timeout ? '0 : elapsed_q + 1'b1;
		end
	end

	// ****************************************
	// power mode tracking
	// ****************************************
	always_comb begin
		mode_d = mode_q;
		unique case (mode_q)
			wdtw_pkg::WDTW_RUN: begin
				if (i_power_save_sleep)
					mode_d = wdtw_pkg::WDTW_SLEEP;
				else if (i_power_save_idle)
					mode_d = wdtw_pkg::WDTW_IDLE;
			end
			wdtw_pkg::WDTW_SLEEP,
			wdtw_pkg::WDTW_IDLE: begin
				if (i_exit_low_power || dev_rst)
					mode_d = wdtw_pkg::WDTW_RUN;
			end
			default: mode_d = wdtw_pkg::WDTW_RUN;
		endcase
	end

	// ****************************************
	// registers and outputs
	// ****************************************
	wire wr_rc  = wr_en && wr_strb[0] && addr_is(wr_addr, wdtw_pkg::OFS_RSTCTL);
	wire wr_cfg = wr_en && wr_strb[0] && addr_is(wr_addr, wdtw_pkg::OFS_CFG);
	wire wr_err = !(addr_is(wr_addr, wdtw_pkg::OFS_RSTCTL)
	                || addr_is(wr_addr, wdtw_pkg::OFS_CFG)
	                || addr_is(wr_addr, wdtw_pkg::OFS_COUNT));
	wire rd_rc  = addr_is(rd_addr, wdtw_pkg::OFS_RSTCTL);
	wire rd_cfg = addr_is(rd_addr, wdtw_pkg::OFS_CFG);
	wire rd_cnt = addr_is(rd_addr, wdtw_pkg::OFS_COUNT);
	wire rd_err = !(rd_rc || rd_cfg || rd_cnt);

	wire [31:0] rc_word = (32'(soft_en_q)    << wdtw_pkg::BIT_SWEN)
	                    | (32'(flag_to_q)    << wdtw_pkg::BIT_TO)
	                    | (32'(stat_sleep_q) << wdtw_pkg::BIT_SLEEP)
	                    | (32'(stat_idle_q)  << wdtw_pkg::BIT_IDLE);
	wire [31:0] rd_data = rd_rc  ? rc_word
	                    : rd_cfg ? 32'(cfg_q)
	                    : rd_cnt ? 32'(elapsed_q)
	                    : 32'h0000_0000;

	// software writes zero to clear status; a same-cycle set wins
	wire to_d    = rst_d || wake_d
	               || (flag_to_q && !(wr_rc && !wr_data[wdtw_pkg::BIT_TO]));
	wire sleep_d = i_power_save_sleep
	               || (stat_sleep_q && !(wr_rc && !wr_data[wdtw_pkg::BIT_SLEEP]));
	wire idle_d  = i_power_save_idle
	               || (stat_idle_q && !(wr_rc && !wr_data[wdtw_pkg::BIT_IDLE]));
	wire swen_d  = dev_rst ? 1'b0
	             : wr_rc   ? wr_data[wdtw_pkg::BIT_SWEN]
	             : soft_en_q;

	// ****************************************
	// configuration and soft enable
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			cfg_q <= wdtw_pkg::CFG_RESET;
		end else if (wr_cfg) begin
			cfg_q <= wr_data[7:0];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			soft_en_q <= 1'b0;
		end else begin
			soft_en_q <= swen_d;
		end
	end

	// ****************************************
	// status flags
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			flag_to_q <= 1'b0;
		end else begin
			flag_to_q <= to_d;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			stat_sleep_q <= 1'b0;
		end else begin
			stat_sleep_q <= sleep_d;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			stat_idle_q <= 1'b0;
		end else begin
			stat_idle_q <= idle_d;
		end
	end

	// ****************************************
	// power mode
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			mode_q <= wdtw_pkg::WDTW_RUN;
		end else begin
			mode_q <= mode_d;
		end
	end

	// ****************************************
	// time-out outputs and oscillator enable
	// ****************************************
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_wdt_reset <= 1'b0;
		end else begin
			o_wdt_reset <= rst_d;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_wake <= 1'b0;
		end else begin
			o_wake <= wake_d;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_low_power_rc_osc_en <= 1'b0;
		end else begin
			o_low_power_rc_osc_en <= wdt_en;
		end
	end

	// ****************************************
	// bus slave
	// ****************************************
	wdtw_axil u_bus (
		.i_mclk    (i_mclk),
		.i_resetn  (i_resetn),
		.i_awaddr  (i_awaddr),
		.i_awvalid (i_awvalid),
		.o_awready (o_awready),
		.i_wdata   (i_wdata),
		.i_wstrb   (i_wstrb),
		.i_wvalid  (i_wvalid),
		.o_wready  (o_wready),
		.o_bresp   (o_bresp),
		.o_bvalid  (o_bvalid),
		.i_bready  (i_bready),
		.i_araddr  (i_araddr),
		.i_arvalid (i_arvalid),
		.o_arready (o_arready),
		.o_rdata   (o_rdata),
		.o_rresp   (o_rresp),
		.o_rvalid  (o_rvalid),
		.i_rready  (i_rready),
		.o_wr_en   (wr_en),
		.o_wr_addr (wr_addr),
		.o_wr_data (wr_data),
		.o_wr_strb (wr_strb),
		.i_wr_err  (wr_err),
		.o_rd_addr (rd_addr),
		.i_rd_data (rd_data),
		.i_rd_err  (rd_err)
	);
endmodule
